// [lowpower_cyclic_wake_tb_top.sv]
/*
  lowpower_cyclic_wake_tb_top: host and device ends joined by the link.
  assumes a shortened tick of 2 cycles and the package constants.
*/
module lowpower_cyclic_wake_tb_top
  import lpcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  cfg_t cfg; // random configuration for normal mode
  logic debug = 1'b0;
  logic lp_req = 1'b0;
  logic lp_on = 1'b0;
  logic safe = 1'b0;
  logic auto_ack = 1'b1;
  logic hv = 1'b0;
  logic [15:0] hc = 16'h0000;
  logic [2:0] io = 3'h0;
  pwr_t pwr;
  mode_t mode;
  logic wake, rdy, rv, iseen;
  logic [15:0] rd;
  int err_total = 0;
  int checked = 0;
  logic [3:0] exp_q[$]; // model: mode each queued user command should meet
  lpcw_if link();
  lpcw_device #(.TICK_CYC(2)) u_lpcw_device(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link.dev), .cfg_i(cfg),
    .debug_i(debug), .lp_req_i(lp_req), .lp_supply_on_i(lp_on), .safe_i(safe), .safe_case_a_i(safe),
    .io_in_i(io), .pwr_o(pwr), .mode_o(mode), .wake_o(wake));
  lpcw_host u_lpcw_host(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link.host), .cmd_valid_i(hv), .cmd_i(hc),
    .cmd_ready_o(rdy), .auto_ack_i(auto_ack), .resp_valid_o(rv), .resp_o(rd), .int_seen_o(iseen));
  lpcw_monitor #(.TICK_CYC(2)) u_lpcw_monitor(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid(link.cmd_valid),
    .cmd(link.cmd), .resp_valid(link.resp_valid), .resp(link.resp), .int_pulse(link.int_pulse),
    .rst_req(link.rst_req));
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_bit(ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'b1; n++) @(negedge clk_sys_i);
    chk(s, 1'b1);
  endtask
  task automatic wait_mode(input mode_t m, input int lim);
    for (int n = 0; n < lim && mode !== m; n++) @(negedge clk_sys_i);
    chk(mode, m);
  endtask
  // one command through the user port, held until an edge sees ready, answer awaited
  task send(input logic [15:0] c, input mode_t m);
    wait_bit(rdy, 100);
    exp_q.push_back(m);
    @(posedge clk_sys_i) hv <= 1'b1;
    hc <= c;
    do @(posedge clk_sys_i); while (rdy !== 1'b1);
    hv <= 1'b0;
    wait_bit(rv, 10);
  endtask
  task go_lp(input logic on);
    send({CMD_CINT_HI, 8'h00}, M_NORMAL);
    @(posedge clk_sys_i) lp_on <= on;
    lp_req <= 1'b1;
    @(posedge clk_sys_i) lp_req <= 1'b0;
    wait_mode(on ? M_LP_ON : M_LP_OFF, 10);
    @(negedge clk_sys_i);
    chk({pwr.can_on, pwr.lin_on, pwr.aux_regulator, pwr.can5v}, 4'h0);
  endtask
  task results;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // interrupt pulses only ever in supply-on low power
  always @(negedge clk_sys_i) if (link.int_pulse === 1'b1) chk(mode, M_LP_ON);
  // every answer carries the mode the model expects at the command
  always @(negedge clk_sys_i) if (rv === 1'b1) chk(rd[11:8], (exp_q.size() > 0) ? exp_q.pop_front() : 4'hF);
  initial
  begin
    #(10 * 90000);
    err_total++;
    results();
  end
  initial
  begin
    void'($urandom(32'h5278BCB8));
    cfg = 16'($urandom);
    cfg.sense_sel = 3'h0;
    cfg.son_sel = 2'h3;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk({link.rst_req, pwr.aux_regulator, pwr.can_on}, 3'h4);
    chk({pwr.can_term_gnd, pwr.can_wake}, 2'h2);
    chk({pwr.lin_pullup, pwr.lin_term, pwr.lin_on}, 3'h4);
    wait_mode(M_INIT, 2100);
    @(negedge clk_sys_i);
    chk(pwr.can5v, 1'b0);
    send(CMD_GO_NORMAL, M_INIT);
    wait_mode(M_NORMAL, 10);
    @(negedge clk_sys_i);
    chk({pwr.can5v, pwr.aux_regulator, pwr.can_on, pwr.lin_on}, {cfg.can5v, cfg.aux, cfg.can, cfg.lin});
    // acknowledged periods keep the stay going, wake command ends it
    go_lp(1'b1);
    wait_bit(iseen, 7000);
    repeat (13000) @(negedge clk_sys_i);
    chk(mode, M_LP_ON);
    send(CMD_WAKE, M_LP_ON);
    wait_mode(M_NORMAL_REQ, 10);
    // no acknowledge: the first pulse passes, the period end after it resets
    send(CMD_GO_NORMAL, M_NORMAL_REQ);
    @(posedge clk_sys_i) auto_ack <= 1'b0;
    go_lp(1'b1);
    repeat (8000) @(negedge clk_sys_i);
    chk(mode, M_LP_ON);
    wait_mode(M_RESET, 5000);
    wait_mode(M_NORMAL_REQ, 2100);
    chk(iseen, 1'b0);
    // contact closes after the first on-time: the next one wakes
    @(posedge clk_sys_i) auto_ack <= 1'b1;
    send(CMD_GO_NORMAL, M_NORMAL_REQ);
    go_lp(1'b0);
    repeat (6100) @(negedge clk_sys_i);
    chk({pwr.io0_hs, pwr.io0_ls}, {cfg.io0_hs, !cfg.io0_hs});
    repeat (3400) @(negedge clk_sys_i);
    chk(mode, M_LP_OFF);
    chk({pwr.io0_hs, pwr.io0_ls}, 2'h0);
    @(posedge clk_sys_i) io <= 3'(1 << ($urandom % 3));
    wait_bit(wake, 9500);
    wait_mode(M_RESET, 5);
    // second reset with the debug strap set
    @(posedge clk_sys_i) debug <= 1'b1;
    rst_i <= 1'b1;
    @(posedge clk_sys_i) rst_i <= 1'b0;
    wait_mode(M_INIT, 2100);
    @(negedge clk_sys_i);
    chk(pwr.can5v, 1'b1);
    results();
  end
endmodule

// [lpcw_device.sv]
/*
  lpcw_device: device end of the low-power sequencer. per-mode supply
  and transceiver enables, cyclic contact sensing in both low-power
  modes and cyclic interrupt with code acknowledge in supply-on mode.
  assumes synchronous io inputs, one clock, host behaves per the link.
*/
module lpcw_device
  import lpcw_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF  // shorten in simulation
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // link
  lpcw_if.dev link,
  // configuration and requests
  input wire cfg_t cfg_i,
  input wire logic debug_i,
  input wire logic lp_req_i,
  input wire logic lp_supply_on_i,
  input wire logic safe_i,
  input wire logic safe_case_a_i,
  // sensed io inputs (io1..io3)
  input wire logic [2:0] io_in_i,
  // outputs
  output pwr_t pwr_o,
  output mode_t mode_o,
  output logic wake_o
);
  // ----------------------------------------------------------------
  // period lookups
  // ----------------------------------------------------------------
  function automatic logic [TW-1:0] sense_ticks(input logic [2:0] sel);
    sense_ticks = (sel == 3'h7) ? SENSE_MAX_US : SENSE_MIN_US << sel;
  endfunction

  function automatic logic [TW-1:0] cint_ticks(input logic [3:0] sel);
    cint_ticks = (sel == CINT_MAX_SEL) ? SENSE_MAX_US : SENSE_MIN_US << sel[2:0];
  endfunction

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  mode_t mode, next_mode;
  logic [15:0] tick_cnt, next_tick_cnt;     // us divider
  logic [TW-1:0] rst_cnt, next_rst_cnt;     // reset-type mode duration
  logic [TW-1:0] sense_cnt, next_sense_cnt; // sense period / on-time
  logic sense_on, next_sense_on;
  logic [12:0] dg_cnt, next_dg_cnt;         // deglitch in cycles
  logic [TW-1:0] int_cnt, next_int_cnt;     // interrupt period
  logic [TW-1:0] int_w, next_int_w;         // interrupt pulse width
  logic int_seen, next_int_seen;            // first pulse issued
  logic acked, next_acked;
  logic code_read, next_code_read;
  logic [7:0] code, next_code;
  logic [7:0] lfsr, next_lfsr;              // code source, free running
  logic cint_en, next_cint_en;
  logic [3:0] cint_sel, next_cint_sel;
  logic [1:0] son_sel, next_son_sel;        // on-time, fixed in init
  logic io0_hs_sel, next_io0_hs_sel;        // pulsed side in low power
  logic dbg, next_dbg;                      // debug strap
  logic strap_done, next_strap_done;
  logic [2:0] io_prev, next_io_prev;
  logic wake, next_wake;
  logic rv, next_rv;
  logic [15:0] rw, next_rw;
  logic tick;
  logic ack_ok;
  logic int_q, next_int_q;                  // interrupt pin, registered
  logic rst_q, next_rst_q;                  // reset pin, registered

  assign tick = (tick_cnt == 16'(TICK_CYC - 1));

  // mode sequencing, timers, command decode
  always_comb
  begin
    next_mode = mode;
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
    next_rst_cnt = rst_cnt;
    next_sense_cnt = sense_cnt;
    next_sense_on = sense_on;
    next_dg_cnt = 13'h0000;
    next_int_cnt = int_cnt;
    next_int_w = (tick && int_w != '0) ? int_w - 20'h00001 : int_w;
    next_int_seen = int_seen;
    next_acked = acked;
    next_code_read = code_read;
    next_code = code;
    next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    next_cint_en = cint_en;
    next_cint_sel = cint_sel;
    next_son_sel = son_sel;
    next_io0_hs_sel = io0_hs_sel;
    next_dbg = dbg;
    next_strap_done = 1'b1;
    next_io_prev = io_in_i;
    next_wake = 1'b0;
    next_rv = link.cmd_valid;
    next_rw = {4'h0, mode, lfsr};
    ack_ok = link.cmd_valid && link.cmd[15:8] == CMD_REFRESH_HI && code_read && link.cmd[7:0] == ~code;
    if (!strap_done)
      next_dbg = debug_i;
    // code read is honoured in any mode
    if (link.cmd_valid && link.cmd == CMD_READ_CODE)
    begin
      next_code = lfsr;
      next_code_read = 1'b1;
    end
    case (mode)
      M_INIT_RESET, M_RESET:
      begin
        if (tick)
          next_rst_cnt = rst_cnt - 20'h00001;
        if (tick && rst_cnt == 20'h00001)
          next_mode = (mode == M_INIT_RESET) ? M_INIT : M_NORMAL_REQ;
      end
      M_INIT, M_NORMAL_REQ:
      begin
        if (mode == M_INIT)
          next_son_sel = cfg_i.son_sel;
        if (link.cmd_valid && link.cmd == CMD_GO_NORMAL)
          next_mode = M_NORMAL;
      end
      M_NORMAL:
      begin
        // period command only takes effect in normal mode
        if (link.cmd_valid && link.cmd[15:8] == CMD_CINT_HI)
        begin
          next_cint_en = 1'b1;
          next_cint_sel = link.cmd[3:0];
        end
        if (lp_req_i)
        begin
          next_mode = lp_supply_on_i ? M_LP_ON : M_LP_OFF;
          next_io0_hs_sel = pwr_o.io0_hs;
          next_sense_cnt = sense_ticks(cfg_i.sense_sel);
          next_sense_on = 1'b0;
          next_int_cnt = cint_ticks(cint_sel);
          next_int_seen = 1'b0;
          next_acked = 1'b0;
          next_code_read = 1'b0;
        end
      end
      M_LP_OFF, M_LP_ON:
      begin
        // cyclic sensing in both low-power modes
        if (tick)
          next_sense_cnt = sense_cnt - 20'h00001;
        if (tick && sense_cnt == 20'h00001)
        begin
          next_sense_on = !sense_on;
          // on-time 200/400/800/1600 us, else restart the period
          next_sense_cnt = sense_on ? sense_ticks(cfg_i.sense_sel) : SON_BASE_US << son_sel;
        end
        // any wake input high, filtered for longer than 30 us
        if (sense_on && |io_in_i)
          next_dg_cnt = (dg_cnt == 13'(DEGLITCH_CYC)) ? dg_cnt : dg_cnt + 13'h0001;
        if (sense_on && |io_in_i && dg_cnt == 13'(DEGLITCH_CYC))
        begin
          next_wake = 1'b1;
          next_sense_on = 1'b0;
          next_mode = (mode == M_LP_ON) ? M_NORMAL_REQ : M_RESET;
          next_rst_cnt = RESET_US;
        end
        if (mode == M_LP_ON && cint_en)
        begin
          // cyclic interrupt only here
          if (tick)
            next_int_cnt = int_cnt - 20'h00001;
          if (ack_ok && int_seen)
            next_acked = 1'b1;
          if (tick && int_cnt == 20'h00001)
          begin
            // an acknowledge in this very cycle still counts
            if (!int_seen || acked || (ack_ok && int_seen))
            begin
              next_int_w = INT_PULSE_US;
              next_int_seen = 1'b1;
              next_acked = 1'b0;
              // a code read landing on the period end still counts
              next_code_read = link.cmd_valid && link.cmd == CMD_READ_CODE;
              next_int_cnt = cint_ticks(cint_sel);
            end
            else
            begin
              next_mode = M_RESET;
              next_rst_cnt = RESET_US;
            end
          end
          // wrong refresh after a pulse is an improper acknowledge
          if (link.cmd_valid && link.cmd[15:8] == CMD_REFRESH_HI && int_seen && !ack_ok)
          begin
            next_mode = M_RESET;
            next_rst_cnt = RESET_US;
          end
        end
        // wake command leaves supply-on low power
        if (mode == M_LP_ON && link.cmd_valid && link.cmd == CMD_WAKE)
          next_mode = M_NORMAL_REQ;
        if (next_mode != mode)
        begin
          next_int_w = '0;
          next_cint_en = 1'b0;
        end
      end
      M_SAFE:
      begin
        // wake on any io level change
        if (io_in_i != io_prev)
        begin
          next_wake = 1'b1;
          next_mode = M_RESET;
          next_rst_cnt = RESET_US;
        end
      end
      default: next_mode = M_INIT_RESET;
    endcase
    if (safe_i && mode != M_INIT_RESET && mode != M_SAFE)
      next_mode = M_SAFE;
    // pins come from flops; decoding the next values keeps their timing
    next_int_q = (next_int_w != '0);
    next_rst_q = (next_mode == M_INIT_RESET) || (next_mode == M_RESET);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode <= M_INIT_RESET;
      tick_cnt <= 16'h0000;
      rst_cnt <= RESET_US;
      sense_cnt <= SENSE_MIN_US;
      sense_on <= 1'b0;
      dg_cnt <= 13'h0000;
      int_cnt <= SENSE_MIN_US;
      int_w <= '0;
      int_seen <= 1'b0;
      acked <= 1'b0;
      code_read <= 1'b0;
      code <= 8'h00;
      lfsr <= LFSR_SEED;
      cint_en <= 1'b0;
      cint_sel <= 4'h0;
      son_sel <= 2'h0;
      io0_hs_sel <= 1'b0;
      dbg <= 1'b0;
      strap_done <= 1'b0;
      io_prev <= 3'h0;
      wake <= 1'b0;
      rv <= 1'b0;
      rw <= 16'h0000;
      int_q <= 1'b0;
      rst_q <= 1'b1;
    end
    else
    begin
      mode <= next_mode;
      tick_cnt <= next_tick_cnt;
      rst_cnt <= next_rst_cnt;
      sense_cnt <= next_sense_cnt;
      sense_on <= next_sense_on;
      dg_cnt <= next_dg_cnt;
      int_cnt <= next_int_cnt;
      int_w <= next_int_w;
      int_seen <= next_int_seen;
      acked <= next_acked;
      code_read <= next_code_read;
      code <= next_code;
      lfsr <= next_lfsr;
      cint_en <= next_cint_en;
      cint_sel <= next_cint_sel;
      son_sel <= next_son_sel;
      io0_hs_sel <= next_io0_hs_sel;
      dbg <= next_dbg;
      strap_done <= next_strap_done;
      io_prev <= next_io_prev;
      wake <= next_wake;
      rv <= next_rv;
      rw <= next_rw;
      int_q <= next_int_q;
      rst_q <= next_rst_q;
    end
  end

  // ----------------------------------------------------------------
  // per-mode enables, one cycle behind the mode
  // ----------------------------------------------------------------
  pwr_t next_pwr, pwr;

  always_comb
  begin
    next_pwr = '0;
    next_pwr.vdd = 1'b1;
    case (mode)
      M_INIT_RESET:
      begin
        next_pwr.can_term_gnd = 1'b1;
        next_pwr.lin_pullup = 1'b1;
      end
      M_INIT, M_RESET, M_NORMAL_REQ:
      begin
        // 5v-can on by default only from a debug power-up
        next_pwr.can5v = (mode == M_INIT) ? dbg : pwr.can5v;
        next_pwr.io0_hs = pwr.io0_hs;
        next_pwr.io1_hs = pwr.io1_hs;
        next_pwr.io1_ls = pwr.io1_ls;
        next_pwr.io0_ls = 1'b0;
      end
      M_NORMAL:
      begin
        // everything follows configuration
        next_pwr.can5v = cfg_i.can5v;
        next_pwr.aux_regulator = cfg_i.aux;
        next_pwr.can_on = cfg_i.can;
        next_pwr.lin_on = cfg_i.lin;
        next_pwr.lin_term = cfg_i.lin;
        next_pwr.can_wake = cfg_i.can_wake;
        next_pwr.lin_wake = cfg_i.lin_wake;
        next_pwr.io_wake = cfg_i.io_wake;
        next_pwr.io0_hs = cfg_i.io0_hs;
        next_pwr.io0_ls = cfg_i.io0_ls;
        next_pwr.io1_hs = cfg_i.io1_hs;
        next_pwr.io1_ls = cfg_i.io1_ls;
      end
      M_LP_OFF, M_LP_ON:
      begin
        // transceivers, 5v-can, aux off; wake per configuration
        next_pwr.vdd = (mode == M_LP_ON);
        next_pwr.can_wake = cfg_i.can_wake;
        next_pwr.lin_wake = cfg_i.lin_wake;
        next_pwr.io_wake = cfg_i.io_wake;
        next_pwr.io0_hs = sense_on && io0_hs_sel;
        next_pwr.io0_ls = sense_on && !io0_hs_sel;
      end
      M_SAFE:
      begin
        next_pwr.vdd = safe_case_a_i;
        next_pwr.can5v = safe_case_a_i && pwr.can5v;
        next_pwr.can_wake = 1'b1;
        next_pwr.lin_wake = 1'b1;
        next_pwr.io_wake_any = 1'b1;
      end
      default: next_pwr.vdd = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      pwr <= '0;
    else
      pwr <= next_pwr;
  end

  assign pwr_o = pwr;
  assign mode_o = mode;
  assign wake_o = wake;
  assign link.resp_valid = rv;
  assign link.resp = rw;
  assign link.int_pulse = int_q;
  assign link.rst_req = rst_q;
endmodule

// [lpcw_host.sv]
/*
  lpcw_host: host end, forwards user commands and answers cyclic
  interrupts with the read-code / inverted-code acknowledge pair.
  assumes the device answers each command the cycle after it.
*/
module lpcw_host
  import lpcw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // link
  lpcw_if.host link,
  // user command port
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_i,
  output logic cmd_ready_o,
  input wire logic auto_ack_i,
  output logic resp_valid_o,
  output logic [15:0] resp_o,
  output logic int_seen_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {H_IDLE = 2'h0, H_WAIT = 2'h1} hstate_t;
  hstate_t st, next_st;
  logic [1:0] step, next_step;     // 0 user, 1 code read, 2 refresh
  logic ack_pend, next_ack_pend;   // pulse seen, acknowledge owed
  logic int_prev, next_int_prev;   // edge detect on the device int
  logic cv, next_cv;
  logic [15:0] cw, next_cw;
  logic rv, next_rv;
  logic [15:0] rw, next_rw;
  logic rdy, next_rdy;
  logic seen, next_seen;

  // next-state computation
  always_comb
  begin
    next_st = st;
    next_step = step;
    next_int_prev = link.int_pulse;
    next_ack_pend = ack_pend;
    next_cv = 1'b0;
    next_cw = cw;
    next_rv = 1'b0;
    next_rw = rw;
    next_seen = seen;
    // acknowledge only after a pulse has been seen
    if (link.int_pulse && !int_prev)
    begin
      next_ack_pend = 1'b1;
      next_seen = 1'b1;
    end
    // a device reset cancels any owed acknowledge along with the seen flag
    if (link.rst_req)
    begin
      next_seen = 1'b0;
      next_ack_pend = 1'b0;
    end
    case (st)
      H_IDLE:
      begin
        if (ack_pend && auto_ack_i)
        begin
          // first read the code
          next_cv = 1'b1;
          next_cw = CMD_READ_CODE;
          next_step = 2'h1;
          next_ack_pend = 1'b0;
          next_st = H_WAIT;
        end
        else if (cmd_valid_i && rdy)
        begin
          // user commands, incl. 0x56xx and 0x5C10, pass as given
          next_cv = 1'b1;
          next_cw = cmd_i;
          next_step = 2'h0;
          next_st = H_WAIT;
        end
      end
      H_WAIT:
      begin
        if (link.resp_valid)
        begin
          if (step == 2'h1)
          begin
            // then refresh with the inverted code, the cycle after the answer
            next_cv = 1'b1;
            next_cw = {CMD_REFRESH_HI, ~link.resp[7:0]};
            next_step = 2'h2;
          end
          else
          begin
            next_rv = (step == 2'h0);
            next_rw = link.resp;
            next_st = H_IDLE;
          end
        end
      end
      default: next_st = H_IDLE;
    endcase
    // ready only when idle and no acknowledge is about to start
    next_rdy = (next_st == H_IDLE) && !(next_ack_pend && auto_ack_i) && !next_cv;
  end

  // registers
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= H_IDLE;
      step <= 2'h0;
      ack_pend <= 1'b0;
      int_prev <= 1'b0;
      cv <= 1'b0;
      cw <= 16'h0000;
      rv <= 1'b0;
      rw <= 16'h0000;
      rdy <= 1'b0;
      seen <= 1'b0;
    end
    else
    begin
      st <= next_st;
      step <= next_step;
      ack_pend <= next_ack_pend;
      int_prev <= next_int_prev;
      cv <= next_cv;
      cw <= next_cw;
      rv <= next_rv;
      rw <= next_rw;
      rdy <= next_rdy;
      seen <= next_seen;
    end
  end

  assign link.cmd_valid = cv;
  assign link.cmd = cw;
  assign cmd_ready_o = rdy;
  assign resp_valid_o = rv;
  assign resp_o = rw;
  assign int_seen_o = seen;
endmodule

// [lpcw_if.sv]
/*
  lpcw_if: word-level command link between the host and the device.
  assumes both ends share clk_sys_i; cmd_valid and resp_valid are pulses.
*/
interface lpcw_if;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic cmd_valid;      // host: one-cycle command strobe
  logic [15:0] cmd;     // host: command word
  logic resp_valid;     // device: one-cycle answer strobe
  logic [15:0] resp;    // device: answer word
  logic int_pulse;      // device: cyclic interrupt level pulse
  logic rst_req;        // device: reset to the host, active high

  modport dev (input cmd_valid, input cmd, output resp_valid, output resp, output int_pulse, output rst_req);
  modport host (output cmd_valid, output cmd, input resp_valid, input resp, input int_pulse, input rst_req);
endinterface

// [lpcw_monitor.sv]
/*
  lpcw_monitor: timing checks on the link between host and device ends.
  assumes one clock for both ends and interrupt period selection 0.
*/
module lpcw_monitor
  import lpcw_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // link
  input wire logic cmd_valid,
  input wire logic [15:0] cmd,
  input wire logic resp_valid,
  input wire logic [15:0] resp,
  input wire logic int_pulse,
  input wire logic rst_req
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INT_CYC = int'(INT_PULSE_US) * TICK_CYC;
  localparam int RST_CYC = int'(RESET_US) * TICK_CYC;
  localparam int PER_CYC = int'(SENSE_MIN_US) * TICK_CYC;
  logic [7:0] code_q; // last code answered
  logic int_d; // interrupt one cycle late
  logic armed; // a pulse was seen in this low-power stay
  int int_cnt; // cycles of interrupt high
  int rst_cnt; // cycles of reset high
  int gap; // cycles since last interrupt rise
  // helper counters; the tolerance on reset length covers the tick phase
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_q <= 8'h00;
      int_d <= 1'b0;
      armed <= 1'b0;
      int_cnt <= 0;
      rst_cnt <= 0;
      gap <= 0;
    end
    else
    begin
      if (resp_valid)
        code_q <= resp[7:0];
      int_d <= int_pulse;
      int_cnt <= int_pulse ? int_cnt + 1 : 0;
      rst_cnt <= rst_req ? rst_cnt + 1 : 0;
      gap <= (int_pulse && !int_d) ? 0 : gap + 1;
      if (rst_req || (cmd_valid && cmd == CMD_WAKE))
        armed <= 1'b0;
      else if (int_pulse && !int_d)
        armed <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_resp_timing: assert property (cmd_valid |=> resp_valid)
    else $error("command not answered one cycle later");
  a_resp_cause: assert property (resp_valid |-> $past(cmd_valid))
    else $error("answer without a command");
  a_cmd_spacing: assert property (cmd_valid |=> !cmd_valid)
    else $error("commands closer than the answer");
  a_ack_inverted: assert property ((cmd_valid && cmd == CMD_READ_CODE) ##1 resp_valid |=>
    cmd_valid && cmd == {CMD_REFRESH_HI, ~code_q}) else $error("acknowledge not the inverted code");
  a_int_width: assert property ($fell(int_pulse) |-> int_cnt == INT_CYC)
    else $error("interrupt pulse width wrong");
  a_rst_width: assert property ($fell(rst_req) |-> rst_cnt inside {[RST_CYC - TICK_CYC - 1:RST_CYC + TICK_CYC + 1]})
    else $error("reset length wrong");
  a_int_no_reset: assert property (int_pulse |-> !rst_req)
    else $error("interrupt during reset");
  a_int_period: assert property ($rose(int_pulse) && armed |-> gap inside {[PER_CYC - 2:PER_CYC]})
    else $error("interrupt period wrong");
  c_int: cover property ($rose(int_pulse));
  c_wake_cmd: cover property (cmd_valid && cmd == CMD_WAKE);
  c_reset: cover property ($rose(rst_req));
endmodule

// [lpcw_pkg.sv]
/*
  lpcw_pkg: shared types, command codes and timing constants for the
  low-power cyclic wake sequencer and its host end.
  assumes a single 100 MHz system clock on both ends.
*/
package lpcw_pkg;
  // ----------------------------------------------------------------
  // clock and tick timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;                         // 100 MHz
  localparam int TICK_NS = 1000;                             // timers run in 1 us ticks
  localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;     // cycles per tick
  localparam int DEGLITCH_NS = 30000;                        // 30 us sense filter
  localparam int DEGLITCH_CYC = DEGLITCH_NS / CLK_PERIOD_NS; // filter in cycles
  localparam int TW = 20;                                    // tick timer width

  // ----------------------------------------------------------------
  // durations in ticks (us)
  // ----------------------------------------------------------------
  localparam logic [TW-1:0] SENSE_MIN_US = 20'h00BB8;        // 3.0 ms
  localparam logic [TW-1:0] SENSE_MAX_US = 20'h7D000;        // 512 ms
  localparam logic [TW-1:0] SON_BASE_US = 20'h000C8;         // 200 us
  localparam logic [TW-1:0] RESET_US = 20'h003E8;            // 1.0 ms reset time
  localparam logic [TW-1:0] INT_PULSE_US = 20'h00064;        // 100 us int pulse
  localparam logic [3:0] CINT_MAX_SEL = 4'hE;                // index of 512 ms

  // ----------------------------------------------------------------
  // command words
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_READ_CODE = 16'h1B00;
  localparam logic [7:0] CMD_REFRESH_HI = 8'h5A;
  localparam logic [7:0] CMD_CINT_HI = 8'h56;
  localparam logic [15:0] CMD_WAKE = 16'h5C10;
  localparam logic [15:0] CMD_GO_NORMAL = 16'h5A00;
  localparam logic [7:0] LFSR_SEED = 8'hA5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    M_INIT_RESET = 4'h0,
    M_INIT = 4'h1,
    M_RESET = 4'h2,
    M_NORMAL_REQ = 4'h3,
    M_NORMAL = 4'h4,
    M_LP_OFF = 4'h5,
    M_LP_ON = 4'h6,
    M_SAFE = 4'h7
  } mode_t;

  typedef struct packed {
    logic can5v;
    logic aux;
    logic can;
    logic lin;
    logic can_wake;
    logic lin_wake;
    logic io_wake;
    logic io0_hs;
    logic io0_ls;
    logic io1_hs;
    logic io1_ls;
    logic [2:0] sense_sel;
    logic [1:0] son_sel;
  } cfg_t;

  typedef struct packed {
    logic vdd;
    logic can5v;
    logic aux_regulator;
    logic can_on;
    logic can_wake;
    logic can_term_gnd;
    logic lin_on;
    logic lin_pullup;
    logic lin_term;
    logic lin_wake;
    logic io_wake;
    logic io_wake_any;
    logic io0_hs;
    logic io0_ls;
    logic io1_hs;
    logic io1_ls;
  } pwr_t;
endpackage
